// *** rtl/qsi_cfg.svh ***
`ifndef QSI_CFG_SVH
`define QSI_CFG_SVH
// Host I/O window geometry
`define QSI_ADDR_W          16
`define QSI_PORT_COUNT      4
`define QSI_WINDOW_SPAN     16'h0008
`define QSI_WINDOW_SHIFT    3
`define QSI_STATUS_OFFSET   3'h7
`define QSI_DEFAULT_BASE    16'h0280
// Pending summary field layout
`define QSI_PEND_LSB        0
`define QSI_PEND_MSB        3
`define QSI_UNDRIVEN_VALUE  4'h0
// Prescale select encodings
`define QSI_SEL_QUARTER     2'h0
`define QSI_SEL_HALF        2'h1
`define QSI_SEL_UNITY       2'h2
// Divide ratios
`define QSI_RATIO_QUARTER   3'h4
`define QSI_RATIO_HALF      3'h2
`define QSI_RATIO_UNITY     3'h1
`define QSI_PRESCALE_CNT_W  2
`endif

// *** rtl/qsi_pkg.sv ***
package qsi_pkg;
  typedef enum logic [1:0] {
    prescale_quarter = 2'h0,
    prescale_half    = 2'h1,
    prescale_unity   = 2'h2
  } prescale_select_setting_t;

  typedef enum logic {
    irqModeNormal = 1'b0,
    irqModeShared = 1'b1
  } irq_mode_t;

  typedef struct packed {
    logic        readStrobe;
    logic [15:0] address;
  } host_read_t;

  typedef struct packed {
    logic       hit;
    logic [7:0] data;
  } host_answer_t;
endpackage

// *** rtl/port_irq_output.sv ***
`timescale 1ns/1ps
`include "qsi_cfg.svh"
module port_irq_output
  import qsi_pkg::*;
(
  // Clocking
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Per-port controls
  input  wire logic              uartIrq,
  input  wire qsi_pkg::irq_mode_t irqMode,
  input  wire logic              pullDownFitted,
  // Request line drive
  output logic                   irqOut,
  output logic                   irqOutEn
);
  import qsi_pkg::*;

  logic next_irqOut;
  logic next_irqOutEn;

  // Shared mode drives only the high level, so the line idles low through the
  // pull-down; without it the line never sees a clean edge.
  always_comb begin
    next_irqOut   = uartIrq;
    next_irqOutEn = 1'b1;
    if (irqMode == irqModeShared) begin // see [R12]
      next_irqOut   = uartIrq & pullDownFitted; // see [R13]
      next_irqOutEn = uartIrq & pullDownFitted; // see [R13]
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irqOut   <= 1'b0;
      irqOutEn <= 1'b0;
    end else begin
      irqOut   <= next_irqOut;
      irqOutEn <= next_irqOutEn;
    end
  end
endmodule

// *** rtl/quad_serial_irq_status_clock.sv ***
// Operation
// [R1] Read-only 8-bit register flags each port with an interrupt pending.
// [R2] Bits 0..3 follow port 1..4 interrupt lines.
// [R3] Register decoded at offset 7 of each port's eight-location window.
// [R4] All four decoded copies return the same contents.
// [R5] Bits 4..7 undriven; host treats them as undefined. The code returns them as QSI_UNDRIVEN_VALUE (4'h0).
// [R6] UART reference clock prescaled by 4, 2 or 1 from one setting.
// [R7] Divide by 4 gives conventional rates up to 115.2 kbit/s.
// [R8] Divide by 2 doubles rates, up to 230.4 kbit/s.
// [R9] Divide by 1 reaches 460.8 kbit/s with divisor one.
// [R10] Host divisor in divide-by-1 is 460800 over the wanted rate.
// [R11] Host divisor in divide-by-2 is 230400 over the wanted rate.
// [R12] Each port offers normal or shared interrupt output mode.
// [R13] Shared output without a pull-down cannot assert a request.
// [R14] Host decode compares all 16 address bits.
// [R15] Each port takes eight locations; port n at base plus 8(n-1).
// [R16] Reading the register has no side effect.
`timescale 1ns/1ps
`include "qsi_cfg.svh"
module quad_serial_irq_status_clock
  import qsi_pkg::*;
#(
  parameter int PORTS = `QSI_PORT_COUNT
)
(
  // Clocking
  input  wire logic                             clock,
  input  wire logic                             sys_rst,
  // Host I/O read
  input  wire qsi_pkg::host_read_t              hostRead,
  input  wire logic [15:0]                      portBase,
  output qsi_pkg::host_answer_t                 hostAnswer,
  // UART cores
  input  wire logic [PORTS-1:0]                 uartIrq,
  output logic                                  uartClockEnable,
  // Settings
  input  wire qsi_pkg::prescale_select_setting_t prescaleSelect,
  input  wire qsi_pkg::irq_mode_t [PORTS-1:0]   irqModeSetting,
  input  wire logic [PORTS-1:0]                 pullDownFitted,
  // Interrupt request lines
  output logic [PORTS-1:0]                      irqOut,
  output logic [PORTS-1:0]                      irqOutEn
);
  import qsi_pkg::*;

  // Elaboration checks: one summary bit per port, a power-of-two window span,
  // a counter wide enough for the largest ratio
  if (PORTS != `QSI_PORT_COUNT) begin : gBadPorts
    $error("PORTS must equal the four status bits");
  end

  if ((`QSI_PEND_MSB - `QSI_PEND_LSB + 1) != PORTS) begin : gBadField
    $error("Pending field width must equal PORTS");
  end

  if ((1 << `QSI_WINDOW_SHIFT) != `QSI_WINDOW_SPAN) begin : gBadSpan
    $error("Window span must equal two to the window shift");
  end

  if (`QSI_RATIO_QUARTER > (1 << `QSI_PRESCALE_CNT_W)) begin : gBadCount
    $error("Prescale counter too narrow for the divide-by-4 ratio");
  end

  // Address decode: one full-width comparator per port window. The extra top
  // bit stops a window near the end of I/O space wrapping onto low addresses.
  logic [`QSI_ADDR_W:0] windowStatus [PORTS];
  logic [PORTS-1:0]     windowHit;
  logic                 statusHit;
  logic [7:0]           summary;

  always_comb begin
    for (int w = 0; w < PORTS; w++) begin
      windowStatus[w] = {1'b0, portBase} + 17'(w * `QSI_WINDOW_SPAN) + 17'(`QSI_STATUS_OFFSET); // see [R3] [R15]
      windowHit[w]    = ({1'b0, hostRead.address} == windowStatus[w]); // see [R14]
    end
    // Every window answers with one shared summary
    statusHit = |windowHit; // see [R4]
    // Upper bits have no UART behind them and read as a fixed value
    summary   = {`QSI_UNDRIVEN_VALUE, uartIrq}; // see [R1] see [R2] see [R5]
  end

  // Answer register; reads are pure, pending bits only follow the UARTs
  host_answer_t next_hostAnswer;

  always_comb begin
    next_hostAnswer.hit  = hostRead.readStrobe && statusHit;
    next_hostAnswer.data = hostAnswer.data;
    if (hostRead.readStrobe && statusHit) begin
      next_hostAnswer.data = summary; // see [R16]
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hostAnswer <= '0;
    end else begin
      hostAnswer <= next_hostAnswer;
    end
  end

  // Prescaler: one-cycle enable every 4, 2 or 1 clocks. The UARTs run on the
  // same clock and take this pulse as their reference tick, so no second
  // clock domain appears.
  logic [`QSI_PRESCALE_CNT_W-1:0] prescaleCount;
  logic [`QSI_PRESCALE_CNT_W-1:0] next_prescaleCount;
  logic [2:0]                     ratio;
  logic [2:0]                     lastCount;
  logic                           next_uartClockEnable;

  // Select code 3 has no ratio of its own; it falls back to divide-by-4 so a
  // missing setting still gives the conventional rates. A count already past
  // a newly chosen last value wraps on the next clock rather than running on.

  always_comb begin
    unique case (prescaleSelect) // see [R6]
      prescale_quarter: ratio = `QSI_RATIO_QUARTER; // see [R7]
      prescale_half:    ratio = `QSI_RATIO_HALF; // see [R8]
      prescale_unity:   ratio = `QSI_RATIO_UNITY; // see [R9]
      default:          ratio = `QSI_RATIO_QUARTER;
    endcase
    lastCount = ratio - 3'h1;
    if (3'(prescaleCount) >= lastCount) begin
      next_prescaleCount   = '0;
      next_uartClockEnable = 1'b1;
    end else begin
      next_prescaleCount   = prescaleCount + 2'h1;
      next_uartClockEnable = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prescaleCount   <= '0;
      uartClockEnable <= 1'b0;
    end else begin
      prescaleCount   <= next_prescaleCount;
      uartClockEnable <= next_uartClockEnable;
    end
  end

  // Per-port interrupt output stage
  for (genvar p = 0; p < PORTS; p++) begin : gPort
    port_irq_output irqStage (
      .clock          (clock),
      .sys_rst        (sys_rst),
      .uartIrq        (uartIrq[p]),
      .irqMode        (irqModeSetting[p]),
      .pullDownFitted (pullDownFitted[p]),
      .irqOut         (irqOut[p]),
      .irqOutEn       (irqOutEn[p])
    );
  end
endmodule

// *** dv/quad_serial_irq_status_clock_assertions.sv ***
`timescale 1ns/1ps
module quad_serial_irq_status_clock_assertions
  import qsi_pkg::*;
#(
  parameter int PORTS = 4
)
(
  // Watched ports
  input wire logic                              clock,
  input wire logic                              sys_rst,
  input wire qsi_pkg::host_read_t               hostRead,
  input wire logic [15:0]                       portBase,
  input wire qsi_pkg::host_answer_t             hostAnswer,
  input wire logic [PORTS-1:0]                  uartIrq,
  input wire logic                              uartClockEnable,
  input wire qsi_pkg::prescale_select_setting_t prescaleSelect,
  input wire qsi_pkg::irq_mode_t [PORTS-1:0]    irqModeSetting,
  input wire logic [PORTS-1:0]                  pullDownFitted,
  input wire logic [PORTS-1:0]                  irqOut,
  input wire logic [PORTS-1:0]                  irqOutEn
);
  logic [15:0]      off;
  logic [PORTS-1:0] shr;
  logic [PORTS-1:0] expOut;
  logic [PORTS-1:0] expEn;
  logic             sel;
  logic             q;
  logic             h;
  assign off = hostRead.address - portBase;
  assign sel = hostRead.readStrobe && hostRead.address >= portBase && off < 16'h0020 && off[2:0] == 3'h7;
  assign shr = irqModeSetting;
  assign expOut = uartIrq & (~shr | pullDownFitted);
  assign expEn = ~shr | (uartIrq & pullDownFitted);
  assign q = prescaleSelect inside {prescale_quarter, 2'h3};
  assign h = prescaleSelect == prescale_half;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_hit; sel |=> hostAnswer.hit && hostAnswer.data == {4'h0, $past(uartIrq)}; endproperty
  a_hit: assert property (p_hit) else $error("status read answered wrongly");
  property p_miss; !sel |=> !hostAnswer.hit && $stable(hostAnswer.data); endproperty
  a_miss: assert property (p_miss) else $error("stray status answer");
  property p_quarter; uartClockEnable && q |=> (!uartClockEnable || !q) [*3] ##1 (uartClockEnable || !q); endproperty
  a_quarter: assert property (p_quarter) else $error("quarter prescale period wrong");
  property p_half; uartClockEnable && h |=> (!uartClockEnable || !h) ##1 (uartClockEnable || !h); endproperty
  a_half: assert property (p_half) else $error("half prescale period wrong");
  property p_unity; prescaleSelect == prescale_unity |=> uartClockEnable; endproperty
  a_unity: assert property (p_unity) else $error("unity prescale missed a cycle");
  property p_out; 1'b1 |=> irqOut == $past(expOut); endproperty
  a_out: assert property (p_out) else $error("request level wrong");
  property p_en; 1'b1 |=> irqOutEn == $past(expEn); endproperty
  a_en: assert property (p_en) else $error("request drive enable wrong");
  property p_nopd; 1'b1 |=> (irqOutEn & $past(shr) & ~$past(pullDownFitted)) == '0; endproperty
  a_nopd: assert property (p_nopd) else $error("shared line driven without pull-down");
endmodule

bind quad_serial_irq_status_clock quad_serial_irq_status_clock_assertions #(.PORTS(PORTS)) i_chk (.clock, .sys_rst,
  .hostRead, .portBase, .hostAnswer, .uartIrq, .uartClockEnable, .prescaleSelect, .irqModeSetting, .pullDownFitted,
  .irqOut, .irqOutEn);

// *** dv/host_io_model.sv ***
`timescale 1ns/1ps
module host_io_model
  import qsi_pkg::*;
(
  // Clocking
  input  wire logic           clock,
  // Host bus
  output qsi_pkg::host_read_t hostRead
);
  initial hostRead = '0;
  // Released address is inverted so a stale value never decodes by luck
  task automatic read(input logic [15:0] a);
    @(posedge clock);
    #1 hostRead <= {1'b1, a};
    @(posedge clock);
    #1 hostRead <= {1'b0, ~a};
  endtask
endmodule

// *** dv/tb_quad_serial_irq_status_clock.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; $display("mismatch %s %h %h", n, e, a); end end
module tb_quad_serial_irq_status_clock;
  import qsi_pkg::*;
  logic                     clock = 0;
  logic                     sys_rst = 1;
  logic                     uartClockEnable;
  logic [15:0]              portBase = 16'h0280;
  logic [15:0]              off;
  logic [3:0]               uartIrq = 0;
  logic [3:0]               pullDownFitted = 0;
  logic [3:0]               shr;
  logic [3:0]               irqOut;
  logic [3:0]               irqOutEn;
  irq_mode_t [3:0]          mode = '0;
  prescale_select_setting_t prescaleSelect = prescale_quarter;
  host_read_t               hostRead;
  host_answer_t             hostAnswer;
  logic [7:0]               lastData = 0;
  logic [15:0]              corner [4] = '{16'h0007, 16'h001F, 16'h0027, 16'h8007};
  int                       ratio [4] = '{4, 2, 1, 4};
  int                       rates [5] = '{1200, 2400, 4800, 9600, 19200};
  int                       rate;
  int                       mismatches = 0;
  int                       checked = 0;
  int                       n;
  always #50 clock = ~clock;
  quad_serial_irq_status_clock i_dut (.clock, .sys_rst, .hostRead, .portBase, .hostAnswer, .uartIrq,
    .uartClockEnable, .prescaleSelect, .irqModeSetting(mode), .pullDownFitted, .irqOut, .irqOutEn);
  host_io_model i_host (.clock, .hostRead);
  function automatic logic hitExp(logic [15:0] d);
    return d < 16'h0020 && d[2:0] == 3'h7;
  endfunction
  task automatic test_done();
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Divisor the host programs for a wanted rate in each prescale mode
  function automatic int hostDivisor(int s, int r);
    if (s == 1) return 230400 / r;
    if (s == 2) return 460800 / r;
    return 115200 / r;
  endfunction
  initial begin
    void'($urandom(26098));
    repeat (20) @(posedge clock);
    #1 sys_rst = 0;
    // Second pass opens with a reset in mid-run, which must clear every output
    for (int pass = 0; pass < 2; pass++) begin
      if (pass > 0) begin
        sys_rst = 1;
        @(posedge clock);
        #1;
        `CHK("reset", 18'h00000, {hostAnswer, uartClockEnable, irqOut, irqOutEn})
        sys_rst = 0;
        lastData = 8'h00;
        portBase = 16'h0280;
      end
      // Corner offsets first: first copy, last copy, one past the window, a far alias
      for (int k = 0; k < 60; k++) begin
        off = (k < 4) ? corner[k] : 16'($urandom_range(47));
        if (k >= 4) portBase = 16'($urandom_range(16'hFF00));
        uartIrq = 4'($urandom);
        i_host.read(portBase + off);
        if (hitExp(off)) lastData = {4'h0, uartIrq};
        `CHK("hit", hitExp(off), hostAnswer.hit)
        `CHK("status", lastData, hostAnswer.data)
      end
      foreach (ratio[s]) begin
        prescaleSelect = prescale_select_setting_t'(2'(s));
        repeat (8) @(posedge clock);
        n = 0;
        repeat (40) begin
          @(posedge clock);
          #1 n += uartClockEnable;
        end
        rate = rates[$urandom_range(4)];
        `CHK("enables", 40 / ratio[s], n)
        `CHK("bitRate", 40 * hostDivisor(s, rate), n * hostDivisor(2, rate))
      end
      repeat (30) begin
        uartIrq = 4'($urandom);
        pullDownFitted = 4'($urandom);
        shr = 4'($urandom);
        foreach (mode[i]) mode[i] = irq_mode_t'(shr[i]);
        @(posedge clock);
        #1;
        `CHK("irqOut", uartIrq & (~shr | pullDownFitted), irqOut)
        `CHK("irqOutEn", ~shr | (uartIrq & pullDownFitted), irqOutEn)
      end
    end
    test_done();
  end
endmodule
